// file: logic/adc_status_params.svh
`ifndef ADC_STATUS_PARAMS_SVH
`define ADC_STATUS_PARAMS_SVH
// Register byte addresses on the memory-mapped bus
`define STATUS_ADDR 32'hffff0500
`define MODE_ADDR 32'hffff0504
`define CONFIG_ADDR 32'hffff0508
`define IRQ_MASK_ADDR 32'hffff050c
`define CURRENT_RESULT_ADDR 32'hffff0510
`define VOLTAGE_RESULT_ADDR 32'hffff0514
`define TEMP_RESULT_ADDR 32'hffff0518
`define THRESHOLD_ADDR 32'hffff051c
`define THRESH_LIMIT_ADDR 32'hffff0520
`define CURRENT_CONTROL_ADDR 32'hffff0524
// Reset values
`define STATUS_RESET 16'h0000
`define MASK_RESET 8'h00
`define CONFIG_RESET 16'h0000
`define MODE_RESET 16'h0000
// Status bit positions
`define ST_CAL_DONE 15
`define ST_TEMP_ERR 14
`define ST_VOLT_ERR 13
`define ST_CURR_ERR 12
`define ST_THRESH 4
`define ST_OVERRANGE 3
`define ST_TEMP_RDY 2
`define ST_VOLT_RDY 1
`define ST_CURR_RDY 0
// Config bit positions
`define CFG_CURR_EN 0
`define CFG_VOLT_EN 1
`define CFG_OVR_EN 2
`define CFG_TEMP_EN 3
`define CFG_CMP_EN 4
`define CFG_TCNT_EN 5
// Gain field of the current control register
`define GAIN_MSB 3
`define GAIN_LSB 0
// Overrange evaluation interval
`define OVR_INTERVAL_US 125
`define CLK_MHZ 20
`define OVR_INTERVAL_CYCLES (`OVR_INTERVAL_US * `CLK_MHZ)
`endif

// file: logic/adc_status_pkg.sv
/*
 Types shared by the converter status logic.
 Assumes the params header provides positions and addresses.
*/
package adc_status_pkg;
   // One conversion from a channel filter
   typedef struct packed {
      logic valid;
      logic overRange;
      logic underRange;
      logic [15:0] data;
   } conv_result_type;
   // Register bus request
   typedef struct packed {
      logic read;
      logic write;
      logic [31:0] addr;
      logic [15:0] wdata;
   } bus_req_type;
endpackage

// file: logic/result_holder.sv
/*
 One channel result register with range clamp and write lock.
 Assumes conversion strobes are one cycle wide and synchronous to sys_clk.
*/
`timescale 1ns/100ps
module result_holder #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Conversion in
   input wire logic convValid,
   input wire logic overRange,
   input wire logic underRange,
   input wire logic [WIDTH-1:0] convData,
   // Lock control
   input wire logic readyFlag,
   input wire logic coreDown,
   // Result out
   output logic [WIDTH-1:0] result,
   output logic written
);
   // Elaboration check of the result width
   if (WIDTH < 2) begin : badWidth
      $error("WIDTH too small");
   end
   logic [WIDTH-1:0] result_reg;
   logic [WIDTH-1:0] clamped;
   logic allowWrite;
   // Clamp to signed full scale
   assign clamped = overRange ? {1'b0, {(WIDTH-1){1'b1}}} :
      underRange ? {1'b1, {(WIDTH-1){1'b0}}} : convData;
   assign allowWrite = convValid && (!readyFlag || coreDown);
   assign written = allowWrite;
   assign result = result_reg;
   // Result storage
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         result_reg <= '0;
      end else if (allowWrite) begin
         result_reg <= clamped;
      end
   end
endmodule

// file: logic/overrange_timer.sv
/*
 Periodic tick for the overrange evaluation.
 Assumes a free-running sys_clk.
*/
`timescale 1ns/100ps
module overrange_timer #(
   parameter int PERIOD = 2500
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Tick out
   output logic tick
);
   localparam int CW = $clog2(PERIOD + 1);
   // Elaboration check of the interval
   if (PERIOD < 1) begin : badPeriod
      $error("PERIOD must be positive");
   end
   logic [CW-1:0] count_reg;
   assign tick = (count_reg == CW'(PERIOD - 1));
   // Interval counter
   always_ff @(posedge sys_clk) begin
      if (!rst_n || tick) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_reg + 1'b1;
      end
   end
endmodule

// file: logic/adc_status_flag_logic.sv
/*
 Status flags, result handshake, masking and interrupt of a three
 channel converter. Assumes single-cycle read and write strobes from the
 processor bus and one-cycle conversion strobes from the filters.
*/
`timescale 1ns/100ps
`include "adc_status_params.svh"
// Operation
// - Upper status byte bits are flags only, never interrupt sources.
// - Lower status byte bits ORed into one interrupt request.
// - Each lower status bit is masked individually before the OR.
// - Reading the current result clears all ready flags.
// - Current channel off: voltage or temperature read clears all ready flags.
// - Result not overwritten while its ready flag is set.
// - Core powered down: results always take the latest conversion.
// - Bit 15 set on calibration end, cleared by mode register write.
// - Bit 14 flags temperature range error, clamps, clears on valid result.
// - Bit 13 flags voltage range error, clamps, clears on valid result.
// - Bit 12 flags current range error, clamps, clears on valid result.
// - Bits 11 to 5 reserved with no function.
// - Bit 4 sets when absolute current exceeds threshold, comparator on.
// - With threshold counter, bit 4 sets when count reaches limit.
// - Bit 4 clears on reconfiguration or comparator disable.
// - Bit 3 flags gross current overrange, evaluated every 125 us.
// - Bit 3 clears only on overrange enable clear or gain change.
// - Bit 2 sets on temperature result or calibration; clears on temp/current read.
// - Bit 1 sets on voltage result or calibration; clears on voltage/current read.
// - Bit 0 sets on current result or calibration; clears on current read.
module adc_status_flag_logic #(
   parameter int OVR_PERIOD = `OVR_INTERVAL_CYCLES,
   parameter int COUNT_WIDTH = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register bus
   input wire adc_status_pkg::bus_req_type busReq,
   output logic [15:0] rdata,
   output logic rdataValid,
   // Converter channels
   input wire adc_status_pkg::conv_result_type currentConv,
   input wire adc_status_pkg::conv_result_type voltageConv,
   input wire adc_status_pkg::conv_result_type tempConv,
   input wire logic calDone,
   input wire logic grossOverRange,
   input wire logic coreDown,
   // Interrupt to core
   output logic converterIrq
);
   // Elaboration check of the hit counter width
   if (COUNT_WIDTH < 1 || COUNT_WIDTH > 16) begin : badCountWidth
      $error("COUNT_WIDTH out of range");
   end
   logic [15:0] status_reg;
   logic [15:0] status_next;
   logic [7:0] mask_reg;
   logic [15:0] config_reg;
   logic [15:0] mode_reg;
   logic [15:0] threshold_reg;
   logic [COUNT_WIDTH-1:0] limit_reg;
   logic [COUNT_WIDTH-1:0] hits_reg;
   logic [15:0] control_reg;
   logic [15:0] rdata_reg;
   logic rdataValid_reg;
   logic [15:0] currentResult;
   logic [15:0] voltageResult;
   logic [15:0] tempResult;
   logic currentWritten;
   logic voltageWritten;
   logic tempWritten;
   logic ovrTick;
   // Address decode
   wire readCur = busReq.read && busReq.addr == `CURRENT_RESULT_ADDR;
   wire readVolt = busReq.read && busReq.addr == `VOLTAGE_RESULT_ADDR;
   wire readTemp = busReq.read && busReq.addr == `TEMP_RESULT_ADDR;
   wire writeMode = busReq.write && busReq.addr == `MODE_ADDR;
   wire writeCfg = busReq.write && busReq.addr == `CONFIG_ADDR;
   wire writeMask = busReq.write && busReq.addr == `IRQ_MASK_ADDR;
   wire writeThr = busReq.write && busReq.addr == `THRESHOLD_ADDR;
   wire writeLim = busReq.write && busReq.addr == `THRESH_LIMIT_ADDR;
   wire writeCtl = busReq.write && busReq.addr == `CURRENT_CONTROL_ADDR;
   // Configuration fields
   wire curEn = config_reg[`CFG_CURR_EN];
   wire voltEn = config_reg[`CFG_VOLT_EN];
   wire tempEn = config_reg[`CFG_TEMP_EN];
   wire ovrEn = config_reg[`CFG_OVR_EN];
   wire cmpEn = config_reg[`CFG_CMP_EN];
   wire tcntEn = config_reg[`CFG_TCNT_EN];
   wire gainChange = writeCtl &&
      busReq.wdata[`GAIN_MSB:`GAIN_LSB] != control_reg[`GAIN_MSB:`GAIN_LSB];
   // current read clears all ready flags
   wire clearAllReady = readCur || (!curEn && (readVolt || readTemp));
   wire clearTempRdy = clearAllReady || readTemp;
   wire clearVoltRdy = clearAllReady || readVolt;
   wire reconfig = writeMode || writeCfg || writeCtl;
   wire cmpClear = reconfig || !cmpEn;
   // absolute value against threshold
   // The stored result lags one edge, so compare the value being stored
   wire [15:0] newCurrent = currentConv.overRange ? 16'h7fff :
      currentConv.underRange ? 16'h8000 : currentConv.data;
   wire [15:0] absCurrent = newCurrent[15] ? 16'(-newCurrent) : newCurrent;
   wire exceeds = currentWritten && curEn && cmpEn && (absCurrent > threshold_reg);
   wire [COUNT_WIDTH-1:0] hitsPlus = COUNT_WIDTH'(hits_reg + 1'b1);
   wire threshSet = exceeds && (!tcntEn || hitsPlus == limit_reg);
   // Channel result registers
   result_holder #(.WIDTH(16)) currentHold (
      .sys_clk(sys_clk), .rst_n(rst_n),
      .convValid(currentConv.valid && curEn), .overRange(currentConv.overRange),
      .underRange(currentConv.underRange), .convData(currentConv.data),
      .readyFlag(status_reg[`ST_CURR_RDY]), .coreDown(coreDown),
      .result(currentResult), .written(currentWritten)
   );
   result_holder #(.WIDTH(16)) voltageHold (
      .sys_clk(sys_clk), .rst_n(rst_n),
      .convValid(voltageConv.valid && voltEn), .overRange(voltageConv.overRange),
      .underRange(voltageConv.underRange), .convData(voltageConv.data),
      .readyFlag(status_reg[`ST_VOLT_RDY]), .coreDown(coreDown),
      .result(voltageResult), .written(voltageWritten)
   );
   result_holder #(.WIDTH(16)) tempHold (
      .sys_clk(sys_clk), .rst_n(rst_n),
      .convValid(tempConv.valid && tempEn), .overRange(tempConv.overRange),
      .underRange(tempConv.underRange), .convData(tempConv.data),
      .readyFlag(status_reg[`ST_TEMP_RDY]), .coreDown(coreDown),
      .result(tempResult), .written(tempWritten)
   );
   // Overrange interval tick
   overrange_timer #(.PERIOD(OVR_PERIOD)) ovrTimer (
      .sys_clk(sys_clk), .rst_n(rst_n), .tick(ovrTick)
   );
   // Status next value; sets win over clears, except bits 4 and 3, where clears win
   always_comb begin
      status_next = status_reg;
      if (writeMode) status_next[`ST_CAL_DONE] = 1'b0;
      if (calDone) status_next[`ST_CAL_DONE] = 1'b1;
      if (tempWritten) begin
         status_next[`ST_TEMP_ERR] = tempConv.overRange || tempConv.underRange;
      end
      if (voltageWritten) begin
         status_next[`ST_VOLT_ERR] = voltageConv.overRange || voltageConv.underRange;
      end
      if (currentWritten) begin
         status_next[`ST_CURR_ERR] = currentConv.overRange || currentConv.underRange;
      end
      status_next[11:5] = 7'h00;
      if (cmpClear) status_next[`ST_THRESH] = 1'b0;
      if (threshSet && !cmpClear) status_next[`ST_THRESH] = 1'b1;
      if (!ovrEn || gainChange) status_next[`ST_OVERRANGE] = 1'b0;
      if (ovrEn && !gainChange && ovrTick && grossOverRange) begin
         status_next[`ST_OVERRANGE] = 1'b1;
      end
      if (clearTempRdy) status_next[`ST_TEMP_RDY] = 1'b0;
      if (tempWritten || calDone) status_next[`ST_TEMP_RDY] = 1'b1;
      if (clearVoltRdy) status_next[`ST_VOLT_RDY] = 1'b0;
      if (voltageWritten || calDone) status_next[`ST_VOLT_RDY] = 1'b1;
      if (clearAllReady) status_next[`ST_CURR_RDY] = 1'b0;
      if (currentWritten || calDone) status_next[`ST_CURR_RDY] = 1'b1;
   end
   // Status storage; bus writes to its address never reach it
   // status is read only
   always_ff @(posedge sys_clk) begin
      if (!rst_n) status_reg <= `STATUS_RESET;
      else status_reg <= status_next;
   end
   // Software writable registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mask_reg <= `MASK_RESET;
         config_reg <= `CONFIG_RESET;
         mode_reg <= `MODE_RESET;
         threshold_reg <= 16'h0000;
         limit_reg <= '0;
         control_reg <= 16'h0000;
      end else begin
         if (writeMask) mask_reg <= busReq.wdata[7:0];
         if (writeCfg) config_reg <= busReq.wdata;
         if (writeMode) mode_reg <= busReq.wdata;
         if (writeThr) threshold_reg <= busReq.wdata;
         if (writeLim) limit_reg <= busReq.wdata[COUNT_WIDTH-1:0];
         if (writeCtl) control_reg <= busReq.wdata;
      end
   end
   // Threshold hit counter
   always_ff @(posedge sys_clk) begin
      if (!rst_n || cmpClear || threshSet) hits_reg <= '0;
      else if (exceeds) hits_reg <= hitsPlus;
   end
   // Read data mux; unmapped addresses read zero
   logic [15:0] readMux;
   always_comb begin
      case (busReq.addr)
         `STATUS_ADDR: readMux = status_reg;
         `MODE_ADDR: readMux = mode_reg;
         `CONFIG_ADDR: readMux = config_reg;
         `IRQ_MASK_ADDR: readMux = {8'h00, mask_reg};
         `CURRENT_RESULT_ADDR: readMux = currentResult;
         `VOLTAGE_RESULT_ADDR: readMux = voltageResult;
         `TEMP_RESULT_ADDR: readMux = tempResult;
         `THRESHOLD_ADDR: readMux = threshold_reg;
         `THRESH_LIMIT_ADDR: readMux = 16'(limit_reg);
         `CURRENT_CONTROL_ADDR: readMux = control_reg;
         default: readMux = 16'h0000;
      endcase
   end
   // Registered read data
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdata_reg <= 16'h0000;
         rdataValid_reg <= 1'b0;
      end else begin
         rdataValid_reg <= busReq.read;
         if (busReq.read) rdata_reg <= readMux;
      end
   end
   assign rdata = rdata_reg;
   assign rdataValid = rdataValid_reg;
   assign converterIrq = |(status_reg[7:0] & mask_reg);
endmodule

// file: bench/adc_status_flag_logic_properties.sv
/* Port checker for the converter status logic.
   Assumes it is bound into adc_status_flag_logic. */
`timescale 1ns/100ps
`include "adc_status_params.svh"
module adc_status_checker #(
   parameter int OVR_PERIOD = 10
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register bus
   input wire adc_status_pkg::bus_req_type busReq,
   input wire logic [15:0] rdata,
   input wire logic rdataValid,
   // Converter side
   input wire adc_status_pkg::conv_result_type currentConv,
   input wire adc_status_pkg::conv_result_type voltageConv,
   input wire adc_status_pkg::conv_result_type tempConv,
   input wire logic calDone,
   input wire logic grossOverRange,
   input wire logic coreDown,
   // Interrupt
   input wire logic converterIrq
);
   logic [7:0] maskReg;
   logic [15:0] cfgReg;
   int ovrCnt;
   // Decoded bus events and quiet cycles
   wire rdCur = busReq.read && busReq.addr == `CURRENT_RESULT_ADDR;
   wire rdAlt = busReq.read &&
      (busReq.addr == `VOLTAGE_RESULT_ADDR || busReq.addr == `TEMP_RESULT_ADDR);
   wire quiet = !calDone && !currentConv.valid && !voltageConv.valid && !tempConv.valid;
   wire lowOnly = maskReg[7:3] == 5'h00;
   wire curOn = cfgReg[`CFG_CURR_EN];
   wire ovrOn = cfgReg[`CFG_OVR_EN] && maskReg[3] && grossOverRange && !busReq.write;
   // Shadow of mask and config, run length of overrange
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         maskReg <= `MASK_RESET;
         cfgReg <= `CONFIG_RESET;
         ovrCnt <= 0;
      end else begin
         if (busReq.write && busReq.addr == `IRQ_MASK_ADDR) maskReg <= busReq.wdata[7:0];
         if (busReq.write && busReq.addr == `CONFIG_ADDR) cfgReg <= busReq.wdata;
         ovrCnt <= ovrOn ? ovrCnt + 1 : 0;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_rd_valid; busReq.read |=> rdataValid; endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
   property p_unmapped; busReq.read && busReq.addr[31:8] != 24'hffff05 |=> rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_reserved; busReq.read && busReq.addr == `STATUS_ADDR |=> rdata[11:5] == 7'h00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set");
   property p_mask_zero; maskReg == 8'h00 |-> !converterIrq; endproperty
   a_mask_zero: assert property (p_mask_zero) else $error("irq with mask clear");
   property p_curr_irq; currentConv.valid && !currentConv.overRange &&
      !currentConv.underRange && curOn && maskReg[0] |=> converterIrq; endproperty
   a_curr_irq: assert property (p_curr_irq) else $error("no irq on result");
   property p_cal_irq; calDone && maskReg[2:0] != 3'h0 |=> converterIrq; endproperty
   a_cal_irq: assert property (p_cal_irq) else $error("no irq on cal end");
   property p_clr_all; rdCur && quiet && lowOnly |=> !converterIrq; endproperty
   a_clr_all: assert property (p_clr_all) else $error("ready kept after read");
   property p_clr_alt; rdAlt && !curOn && quiet && lowOnly |=> !converterIrq; endproperty
   a_clr_alt: assert property (p_clr_alt) else $error("ready kept, current off");
   property p_keep; rdAlt && converterIrq && maskReg == 8'h01 && curOn |=> converterIrq;
   endproperty
   a_keep: assert property (p_keep) else $error("current ready lost");
   property p_ovr; ovrCnt > OVR_PERIOD + 2 |-> converterIrq; endproperty
   a_ovr: assert property (p_ovr) else $error("overrange not flagged");
   c_clear: cover property (rdCur && converterIrq);
   c_ovr: cover property (ovrCnt > OVR_PERIOD + 2);
   c_cal: cover property (calDone && maskReg != 8'h00);
endmodule

// file: bench/core_sw_model.sv
/* Core software model: one-cycle register reads and writes.
   Assumes the bench calls its tasks; signals move at the falling edge. */
`timescale 1ns/100ps
module core_sw_model (
   // Clock
   input wire logic sys_clk,
   // Register bus
   output adc_status_pkg::bus_req_type busReq,
   input wire logic [15:0] rdata,
   input wire logic rdataValid
);
   initial busReq = '0;
   // Write strobe, address and data inverted once released
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      busReq = {2'b01, a, d};
      @(negedge sys_clk);
      busReq = {2'b00, ~a, ~d};
   endtask
   // Read strobe, data taken while the valid pulse stands
   task automatic rd(input logic [31:0] a, output logic [15:0] d);
      @(negedge sys_clk);
      busReq = {2'b10, a, 16'h0000};
      @(negedge sys_clk);
      d = rdataValid ? rdata : 16'hxxxx;
      busReq = {2'b00, ~a, 16'hffff};
   endtask
endmodule

// file: bench/tb.sv
/* Self-checking bench for the converter status logic.
   Assumes package, header and design compiled first. */
`timescale 1ns/100ps
`include "adc_status_params.svh"
`define CHK(n, e, g) chk(n, e, g)
module tb;
   logic sys_clk;
   logic rst_n;
   logic calDone;
   logic grossOverRange;
   logic coreDown;
   logic converterIrq;
   logic rdataValid;
   logic [15:0] rdata;
   logic [15:0] d;
   logic [15:0] v;
   adc_status_pkg::bus_req_type busReq;
   adc_status_pkg::conv_result_type conv [3];
   int num_errors;
   int check_count;
   localparam logic [31:0] RES [3] = '{`CURRENT_RESULT_ADDR, `VOLTAGE_RESULT_ADDR,
      `TEMP_RESULT_ADDR};
   adc_status_flag_logic #(.OVR_PERIOD(10)) adc_status_flag_logic_inst (.sys_clk(sys_clk),
      .rst_n(rst_n), .busReq(busReq), .rdata(rdata), .rdataValid(rdataValid),
      .currentConv(conv[0]), .voltageConv(conv[1]), .tempConv(conv[2]), .calDone(calDone),
      .grossOverRange(grossOverRange), .coreDown(coreDown), .converterIrq(converterIrq));
   core_sw_model core_sw_model_inst (.sys_clk(sys_clk), .busReq(busReq), .rdata(rdata),
      .rdataValid(rdataValid));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic give_verdict();
      if (num_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [31:0] a, input logic [15:0] x);
      core_sw_model_inst.wr(a, x);
   endtask
   task automatic rr(input logic [31:0] a, input logic [15:0] e);
      core_sw_model_inst.rd(a, v);
      `CHK("read", e, v);
   endtask
   // Status read by software, masked to the bits under test
   task automatic st(input logic [15:0] m, input logic [15:0] e);
      core_sw_model_inst.rd(`STATUS_ADDR, v);
      `CHK("status", e, v & m);
   endtask
   // One conversion strobe; k is {over, under}
   task automatic cv(input int c, input logic [1:0] k, input logic [15:0] x);
      @(negedge sys_clk);
      conv[c] = {1'b1, k, x};
      @(negedge sys_clk);
      conv[c] = {1'b0, 2'b00, ~x};
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // Watchdog
   initial begin
      #200000;
      num_errors++;
      give_verdict();
   end
   initial begin
      rst_n = 1'b0;
      calDone = 1'b0;
      grossOverRange = 1'b0;
      coreDown = 1'b0;
      conv = '{default: '0};
      num_errors = 0;
      check_count = 0;
      d = 16'($urandom(14));
      repeat (16) @(negedge sys_clk);
      rst_n = 1'b1;
      st(16'hffff, 16'h0000);
      rr(32'hffff0600, 16'h0000);
      wr(`STATUS_ADDR, 16'hffff);
      st(16'hffff, 16'h0000);
      wr(`CONFIG_ADDR, 16'h000b);
      wr(`IRQ_MASK_ADDR, 16'h0007);
      // Locked result, then core powered down
      for (int i = 0; i < 4; i++) begin
         coreDown = (i > 1);
         cv(0, 2'b00, d);
         cv(0, 2'b00, d + 16'h0001);
         st(16'h0001, 16'h0001);
         `CHK("irq", 16'h0001, converterIrq);
         rr(RES[0], i > 1 ? d + 16'h0001 : d);
         st(16'h0007, 16'h0000);
         d = 16'($urandom());
      end
      coreDown = 1'b0;
      // Range errors clamp; a clean result clears them
      for (int c = 0; c < 3; c++) begin
         for (int k = 1; k < 3; k++) begin
            cv(c, k[1:0], d);
            st(16'h1000 << c, 16'h1000 << c);
            rr(RES[c], k == 2 ? 16'h7fff : 16'h8000);
            core_sw_model_inst.rd(RES[0], v);
            cv(c, 2'b00, d);
            st(16'h1000 << c, 16'h0000);
            core_sw_model_inst.rd(RES[0], v);
         end
      end
      // Current channel off: other result read clears all; then on: only its own
      wr(`CONFIG_ADDR, 16'h000a);
      cv(1, 2'b00, d);
      cv(2, 2'b00, d);
      st(16'h0007, 16'h0006);
      rr(RES[2], d);
      st(16'h0007, 16'h0000);
      wr(`CONFIG_ADDR, 16'h000b);
      wr(`IRQ_MASK_ADDR, 16'h0001);
      for (int c = 0; c < 3; c++) cv(c, 2'b00, d);
      rr(RES[1], d);
      st(16'h0007, 16'h0005);
      rr(RES[2], d);
      st(16'h0007, 16'h0001);
      rr(RES[0], d);
      // Calibration end, mask off, then mode write
      @(negedge sys_clk);
      calDone = 1'b1;
      @(negedge sys_clk);
      calDone = 1'b0;
      st(16'h8007, 16'h8007);
      wr(`IRQ_MASK_ADDR, 16'h0000);
      `CHK("irq", 16'h0000, converterIrq);
      wr(`MODE_ADDR, 16'h0000);
      st(16'h8000, 16'h0000);
      core_sw_model_inst.rd(RES[0], v);
      // Comparator direct, then counted
      wr(`THRESHOLD_ADDR, 16'd100);
      wr(`CONFIG_ADDR, 16'h0011);
      cv(0, 2'b00, 16'hff6a);
      st(16'h0010, 16'h0010);
      core_sw_model_inst.rd(RES[0], v);
      wr(`CONFIG_ADDR, 16'h0031);
      st(16'h0010, 16'h0000);
      wr(`THRESH_LIMIT_ADDR, 16'h0003);
      for (int i = 0; i < 3; i++) begin
         cv(0, 2'b00, 16'd150 + 16'(i));
         core_sw_model_inst.rd(RES[0], v);
         st(16'h0010, i == 2 ? 16'h0010 : 16'h0000);
      end
      wr(`CONFIG_ADDR, 16'h0021);
      st(16'h0010, 16'h0000);
      // Gross overrange sticks until gain change or disable
      wr(`CONFIG_ADDR, 16'h0005);
      wr(`IRQ_MASK_ADDR, 16'h0008);
      for (int i = 0; i < 2; i++) begin
         grossOverRange = 1'b1;
         repeat (14) @(negedge sys_clk);
         grossOverRange = 1'b0;
         repeat (14) @(negedge sys_clk);
         st(16'h0008, 16'h0008);
         if (i == 0) wr(`CURRENT_CONTROL_ADDR, 16'h0002);
         else wr(`CONFIG_ADDR, 16'h0001);
         st(16'h0008, 16'h0000);
      end
      give_verdict();
   end
endmodule
bind adc_status_flag_logic adc_status_checker #(.OVR_PERIOD(OVR_PERIOD)) adc_status_checker_inst (
   .sys_clk(sys_clk), .rst_n(rst_n), .busReq(busReq), .rdata(rdata), .rdataValid(rdataValid),
   .currentConv(currentConv), .voltageConv(voltageConv), .tempConv(tempConv),
   .calDone(calDone), .grossOverRange(grossOverRange), .coreDown(coreDown),
   .converterIrq(converterIrq));
